/* bench/lcp_panel_model.sv */
// operator keypad and control contact model
`timescale 1ns/100ps
`default_nettype none
module lcp_panel_model
(
  // clock
  input wire logic clock_i,
  // keys by pkg bit position, high while pressed
  output logic [5:0] keys_o,
  // control contacts, high when on
  output logic ext_zero_o,
  output logic ext_hold_o,
  output logic comp_on_o,
  output logic latch_o,
  output logic [4:0] level_o
);
  initial
  begin
    keys_o = 6'h00;
    {ext_zero_o, ext_hold_o, comp_on_o, latch_o} = 4'h0;
    level_o = 5'h00;
  end
  // clean presses only: no contact bounce is modelled
  task automatic press(input int k, input int n);
    @(posedge clock_i);
    #1;
    keys_o[k] = 1'b1;
    repeat (n) @(posedge clock_i);
    #1;
    keys_o[k] = 1'b0;
    repeat (14) @(posedge clock_i);
    #1;
  endtask
  // contacts change together, then settle past the synchronisers
  task automatic set_in(input logic z, h, c, l, input logic [4:0] lv);
    @(posedge clock_i);
    #1;
    ext_zero_o = z;
    ext_hold_o = h;
    comp_on_o = c;
    latch_o = l;
    level_o = lv;
    repeat (8) @(posedge clock_i);
    #1;
  endtask
endmodule
`default_nettype wire

/* bench/lcp_top_asserts.sv */
// port-level assertions for the limit comparator panel block
`timescale 1ns/100ps
`default_nettype none
module lcp_top_asserts
  import lcp_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // watched ports
  input wire logic comp_enable_i,
  input wire logic latch_i,
  input wire logic [LEVELS-1:0] level_select_inputs_i,
  input wire logic meas_valid_i,
  input wire logic meas_stable_i,
  input wire logic level_mode_i,
  input wire logic level_fail_i,
  input wire logic upper_exceed_result_o,
  input wire logic in_range_result_o,
  input wire logic below_lower_result_o,
  input wire logic level_reject_lamp_o,
  input wire logic latch_lamp_o,
  input wire logic hold_active_lamp_o,
  input wire logic held_value_lamp_o,
  input wire logic stable_lamp_o,
  input wire logic standby_lamp_o,
  input wire logic display_on_o,
  input wire logic nv_store_o,
  input wire logic [LEVELS-1:0] level_select_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_result_one_hot: assert property (
    $onehot0({upper_exceed_result_o, in_range_result_o,
    below_lower_result_o})) else $error("two results on");
  a_comp_off_quiet: assert property (
    (!comp_enable_i)[*5] |-> !upper_exceed_result_o &&
    !in_range_result_o && !below_lower_result_o)
    else $error("result while comparator off");
  a_reject_lamp_on: assert property (
    (comp_enable_i && !latch_i)[*5] ##0
    (meas_valid_i && level_mode_i && level_fail_i)
    |=> level_reject_lamp_o) else $error("reject lamp missing");
  a_latch_lamp_follow: assert property (
    $stable(latch_i)[*4] |-> latch_lamp_o == latch_i)
    else $error("latch lamp wrong");
  a_held_needs_hold: assert property (
    held_value_lamp_o |-> hold_active_lamp_o)
    else $error("held lamp without hold");
  a_stable_lamp_follow: assert property (
    meas_valid_i |=> stable_lamp_o == $past(meas_stable_i))
    else $error("stable lamp wrong");
  a_standby_when_off: assert property (
    $stable(display_on_o)[*2] |-> standby_lamp_o != display_on_o)
    else $error("standby lamp wrong");
  a_level_copy_ok: assert property (
    $stable(level_select_inputs_i)[*4] |->
    level_select_o == level_select_inputs_i)
    else $error("level select copy wrong");
  a_store_one_pulse: assert property (
    nv_store_o |=> !nv_store_o) else $error("store pulse too long");
endmodule
bind lcp_top lcp_top_asserts i_lcp_top_asserts (.*);
`default_nettype wire

/* bench/lcp_top_tb_top.sv */
// self-checking testbench for the limit comparator panel block
`timescale 1ns/100ps
`default_nettype none
module lcp_top_tb_top
  import lcp_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  wire cancel_key_i, function_key_i, zero_key_i, up_key_i, down_key_i;
  wire hold_key_i, ext_zero_i, ext_hold_i, comp_enable_i, latch_i;
  wire [LEVELS-1:0] level_select_inputs_i;
  logic meas_valid_i = 1'b0, meas_stable_i = 1'b0, level_mode_i = 1'b0;
  logic level_fail_i = 1'b0, nv_load_i = 1'b0, stored = 1'b0;
  logic signed [VAL_W-1:0] meas_value_i = '0, nv_upper_i = '0;
  logic signed [VAL_W-1:0] nv_lower_i = '0;
  logic nv_store_o, upper_exceed_result_o, in_range_result_o;
  logic below_lower_result_o, upper_exceed_lamp_o, in_range_lamp_o;
  logic below_lower_lamp_o, level_reject_lamp_o, latch_lamp_o;
  logic hold_active_lamp_o, held_value_lamp_o, stable_lamp_o;
  logic zero_lamp_o, standby_lamp_o, display_on_o, entry_o, func_mode_o;
  logic signed [VAL_W-1:0] nv_upper_o, nv_lower_o, disp_value_o;
  logic [DIG_W-1:0] digit_sel_o;
  logic [LEVELS-1:0] level_select_o;
  int err_count = 0;
  int checks_done = 0;
  // short counts keep long presses to tens of cycles
  lcp_top #(.DEBOUNCE_CYCLES(32'h4), .LONG_CYCLES(32'h28),
    .ZERO_CYCLES(32'h14)) i_lcp_top (.*);
  lcp_panel_model i_lcp_panel_model (.clock_i(clock_i),
    .keys_o({hold_key_i, down_key_i, up_key_i, zero_key_i,
    function_key_i, cancel_key_i}), .ext_zero_o(ext_zero_i),
    .ext_hold_o(ext_hold_i), .comp_on_o(comp_enable_i),
    .latch_o(latch_i), .level_o(level_select_inputs_i));
  always #2.5 clock_i = ~clock_i;
  // store pulse lasts one cycle, so it is caught here
  always @(posedge clock_i)
    if (nv_store_o === 1'b1)
      stored <= 1'b1;
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk_v(input logic [VAL_W-1:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_f(input logic [2:0] got, exp);
    chk_v(VAL_W'(got), VAL_W'(exp));
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic kp(input int k, n);
    i_lcp_panel_model.press(k, n);
  endtask
  task automatic si(input logic z, h, c, l, input logic [4:0] v);
    i_lcp_panel_model.set_in(z, h, c, l, v);
  endtask
  task automatic meas(input logic [VAL_W-1:0] v, input logic s);
    step(1);
    meas_value_i = v;
    meas_stable_i = s;
    meas_valid_i = 1'b1;
    step(1);
    meas_valid_i = 1'b0;
    step(3);
  endtask
  task automatic t_compare;
    logic [VAL_W-1:0] v [4] = '{24'h65, 24'h64, 24'hffffce, 24'hffffcd};
    logic [2:0] e [4] = '{3'h4, 3'h2, 3'h2, 3'h1};
    step(1);
    nv_upper_i = 24'h000064;
    nv_lower_i = 24'hffffce;
    nv_load_i = 1'b1;
    step(1);
    nv_load_i = 1'b0;
    si(0, 0, 1, 0, 5'h00);
    for (int i = 0; i < 4; i++)
    begin
      meas(v[i], 1'b0);
      chk_f({upper_exceed_result_o, in_range_result_o,
        below_lower_result_o}, e[i]);
      chk_f({upper_exceed_lamp_o, in_range_lamp_o,
        below_lower_lamp_o}, e[i]);
    end
    si(0, 0, 0, 0, 5'h00);
    meas(24'h000065, 1'b0);
    chk_f({upper_exceed_result_o, in_range_result_o,
      below_lower_result_o}, 3'h0);
    si(0, 0, 1, 0, 5'h15);
    level_mode_i = 1'b1;
    level_fail_i = 1'b1;
    meas(24'h000001, 1'b1);
    chk_f({level_reject_lamp_o, stable_lamp_o, latch_lamp_o},
      3'h6);
    si(0, 0, 1, 1, 5'h00);
    level_fail_i = 1'b0;
    meas(24'h000001, 1'b0);
    chk_f({1'b0, stable_lamp_o, latch_lamp_o}, 3'h1);
    si(0, 0, 1, 0, 5'h00);
    $display("t_compare done");
  endtask
  task automatic t_hold;
    kp(IN_HOLD, 10);
    chk_f({hold_active_lamp_o, held_value_lamp_o, 1'b0}, 3'h4);
    meas(24'h000007, 1'b1);
    meas(24'h000009, 1'b1);
    chk_f({hold_active_lamp_o, held_value_lamp_o, 1'b0}, 3'h6);
    chk_v(disp_value_o, 24'h000007);
    si(0, 1, 1, 0, 5'h00);
    chk_f({hold_active_lamp_o, held_value_lamp_o, 1'b0}, 3'h0);
    si(0, 0, 1, 0, 5'h00);
    kp(IN_HOLD, 10);
    kp(IN_HOLD, 10);
    chk_f({hold_active_lamp_o, held_value_lamp_o, 1'b0}, 3'h0);
    $display("t_hold done");
  endtask
  task automatic t_zero;
    meas(24'h000028, 1'b1);
    kp(IN_ZERO, 35);
    meas(24'h000028, 1'b1);
    chk_f({zero_lamp_o, 2'h0}, 3'h4);
    chk_v(disp_value_o, 24'h000000);
    meas(24'h000037, 1'b1);
    chk_f({zero_lamp_o, 2'h0}, 3'h0);
    si(1, 0, 1, 0, 5'h00);
    si(0, 0, 1, 0, 5'h00);
    meas(24'h000037, 1'b1);
    chk_f({zero_lamp_o, 2'h0}, 3'h4);
    $display("t_zero done");
  endtask
  task automatic t_keys;
    kp(IN_UP, 10);
    chk_v(disp_value_o, 24'h000064);
    kp(IN_CANCEL, 10);
    kp(IN_DOWN, 10);
    chk_v(disp_value_o, 24'hffffce);
    kp(IN_CANCEL, 10);
    kp(IN_FUNC, 60);
    chk_f({func_mode_o, entry_o, 1'b0}, 3'h4);
    kp(IN_CANCEL, 10);
    chk_f({func_mode_o, entry_o, 1'b0}, 3'h0);
    kp(IN_CANCEL, 60);
    chk_f({display_on_o, standby_lamp_o, 1'b0}, 3'h2);
    kp(IN_CANCEL, 60);
    chk_f({display_on_o, standby_lamp_o, 1'b0}, 3'h4);
    $display("t_keys done");
  endtask
  task automatic t_edit;
    kp(IN_UP, 10);
    kp(IN_FUNC, 10);
    kp(IN_UP, 10);
    chk_v(disp_value_o, 24'h000065);
    kp(IN_ZERO, 10);
    chk_v(VAL_W'(digit_sel_o), 24'h000001);
    kp(IN_DOWN, 10);
    chk_v(disp_value_o, 24'h00005b);
    kp(IN_FUNC, 10);
    chk_v(disp_value_o, 24'hffffa5);
    kp(IN_HOLD, 10);
    chk_f({stored, entry_o, 1'b0}, 3'h4);
    chk_v(nv_upper_o, 24'hffffa5);
    chk_v(nv_lower_o, 24'hffffce);
    $display("t_edit done");
  endtask
  initial
  begin
    step(20);
    rst_i = 1'b0;
    t_compare();
    t_hold();
    t_zero();
    t_keys();
    t_edit();
    print_verdict();
  end
  initial
  begin
    #200000;
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire

/* rtl/lcp_key_timer.sv */
// debounce and press-duration timer for one panel key
`timescale 1ns/100ps
`default_nettype none
module lcp_key_timer
  import lcp_pkg::*;
#(
  parameter logic [CNT_W-1:0] DEB_CYC = 32'h10,
  parameter logic [CNT_W-1:0] LONG_CYC = 32'h100
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // synchronised key level, high while pressed
  input wire logic key_i,
  // events
  output logic short_o,
  output logic long_o
);

  logic stable_q;
  logic [CNT_W-1:0] deb_cnt_q;
  logic [CNT_W-1:0] hold_cnt_q;
  logic long_done_q;

  // ------------------------------
  // debounce
  // ------------------------------
  // a level must stay changed for the whole window before it counts
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stable_q <= 1'b0;
      deb_cnt_q <= '0;
    end
    else if (key_i == stable_q)
    begin
      deb_cnt_q <= '0;
    end
    else if (deb_cnt_q >= DEB_CYC - 32'h1)
    begin
      stable_q <= key_i;
      deb_cnt_q <= '0;
    end
    else
    begin
      deb_cnt_q <= deb_cnt_q + 32'h1;
    end
  end

  // ------------------------------
  // press duration
  // ------------------------------
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hold_cnt_q <= '0;
      long_done_q <= 1'b0;
      short_o <= 1'b0;
      long_o <= 1'b0;
    end
    else
    begin
      short_o <= 1'b0;
      long_o <= 1'b0;
      if (stable_q)
      begin
        if (!long_done_q)
        begin
          hold_cnt_q <= hold_cnt_q + 32'h1;
        end
        if (!long_done_q && hold_cnt_q >= LONG_CYC - 32'h1)
        begin
          long_o <= 1'b1; // see RULE_23
          long_done_q <= 1'b1;
        end
      end
      else
      begin
        // short event on release, only if no long event fired
        short_o <= (hold_cnt_q != '0) && !long_done_q; // see RULE_23
        hold_cnt_q <= '0;
        long_done_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* rtl/lcp_pkg.sv */
// constants shared by the limit comparator and panel control logic
package lcp_pkg;

  // ------------------------------
  // clock and timing
  // ------------------------------
  localparam longint CLK_HZ = 200_000_000;
  localparam longint CYC_PER_MS = CLK_HZ / 1000;
  localparam longint DEBOUNCE_MS = 10;
  localparam longint LONG_PRESS_MS = 3000;
  localparam longint ZERO_PRESS_MS = 1000;
  localparam longint DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
  localparam longint LONG_PRESS_CYC = LONG_PRESS_MS * CYC_PER_MS;
  localparam longint ZERO_PRESS_CYC = ZERO_PRESS_MS * CYC_PER_MS;
  localparam int CNT_W = 32;

  // ------------------------------
  // value format
  // ------------------------------
  localparam int VAL_W = 24;
  localparam int DIGITS = 6;
  localparam int DIG_W = 3;
  localparam int LEVELS = 5;
  localparam logic signed [VAL_W-1:0] VAL_MAX = 24'sd999999;
  localparam logic signed [VAL_W-1:0] VAL_MIN = -24'sd999999;
  localparam logic signed [VAL_W-1:0] UPPER_RST = 24'sh000000;
  localparam logic signed [VAL_W-1:0] LOWER_RST = 24'sh000000;

  // ------------------------------
  // synchronised input bit positions
  // ------------------------------
  localparam int IN_CANCEL = 0;
  localparam int IN_FUNC = 1;
  localparam int IN_ZERO = 2;
  localparam int IN_UP = 3;
  localparam int IN_DOWN = 4;
  localparam int IN_HOLD = 5;
  localparam int IN_EXT_ZERO = 6;
  localparam int IN_EXT_HOLD = 7;
  localparam int IN_COMP_ON = 8;
  localparam int IN_LATCH = 9;
  localparam int IN_LEVEL = 10;
  localparam int IN_W = 15;

  // ------------------------------
  // control states
  // ------------------------------
  typedef enum logic [2:0] {
    ST_MEASURE,
    ST_SHOW_UPPER,
    ST_SHOW_LOWER,
    ST_EDIT_UPPER,
    ST_EDIT_LOWER,
    ST_FUNC_SEL
  } lcp_state_t;

endpackage

/* rtl/lcp_top.sv */
// limit comparator, status lamps and front-panel key control
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RULE_01 - upper-exceed contact and lamp on when value is above upper limit
// RULE_02 - in-range contact and lamp on when lower <= value <= upper
// RULE_03 - below-lower contact and lamp on when value is under lower limit
// RULE_04 - reject lamp on when five-level mode reports a failing result
// RULE_05 - latch lamp lit while settings and outputs are latched
// RULE_06 - hold-active lamp follows hold started and stopped
// RULE_07 - held-value lamp lit only while a captured value is held
// RULE_08 - stability lamp follows the stable judgement
// RULE_09 - zero lamp lit when the value sits at zero
// RULE_10 - cancel key over three seconds toggles display; standby lamp when off
// RULE_11 - cancel key press abandons operation and returns to previous state
// RULE_12 - function key over three seconds enters function selection
// RULE_13 - function key during entry flips the sign of the entry
// RULE_14 - zero key picks digit in entry; one-second press zeroes otherwise
// RULE_15 - up key shows upper limit; during entry increments selected digit
// RULE_16 - down key shows lower limit; during entry decrements selected digit
// RULE_17 - hold key toggles hold outside entry
// RULE_18 - hold key during entry confirms and stores the entry
// RULE_19 - limits kept in non-volatile storage and restored at power-up
// RULE_20 - comparison and contacts only while comparator enable is active
// RULE_21 - five level-select inputs choose the comparison level; the code only passes them to level_select_o
// RULE_22 - external zero performs zero adjust; external hold acts as hold key
// RULE_23 - keys debounced and timed on the clock, long action once per press
// RULE_24 - comparison and lamps re-evaluated on each new measured value
module lcp_top
  import lcp_pkg::*;
#(
  parameter logic [CNT_W-1:0] DEBOUNCE_CYCLES = CNT_W'(DEBOUNCE_CYC),
  parameter logic [CNT_W-1:0] LONG_CYCLES = CNT_W'(LONG_PRESS_CYC),
  parameter logic [CNT_W-1:0] ZERO_CYCLES = CNT_W'(ZERO_PRESS_CYC)
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // panel keys, high while pressed
  input wire logic cancel_key_i,
  input wire logic function_key_i,
  input wire logic zero_key_i,
  input wire logic up_key_i,
  input wire logic down_key_i,
  input wire logic hold_key_i,
  // control contacts, high when on
  input wire logic ext_zero_i,
  input wire logic ext_hold_i,
  input wire logic comp_enable_i,
  input wire logic latch_i,
  input wire logic [LEVELS-1:0] level_select_inputs_i,
  // measurement front end
  input wire logic meas_valid_i,
  input wire logic signed [VAL_W-1:0] meas_value_i,
  input wire logic meas_stable_i,
  input wire logic level_mode_i,
  input wire logic level_fail_i,
  // non-volatile limit storage
  input wire logic nv_load_i,
  input wire logic signed [VAL_W-1:0] nv_upper_i,
  input wire logic signed [VAL_W-1:0] nv_lower_i,
  output logic nv_store_o,
  output logic signed [VAL_W-1:0] nv_upper_o,
  output logic signed [VAL_W-1:0] nv_lower_o,
  // result contacts
  output logic upper_exceed_result_o,
  output logic in_range_result_o,
  output logic below_lower_result_o,
  // lamps
  output logic upper_exceed_lamp_o,
  output logic in_range_lamp_o,
  output logic below_lower_lamp_o,
  output logic level_reject_lamp_o,
  output logic latch_lamp_o,
  output logic hold_active_lamp_o,
  output logic held_value_lamp_o,
  output logic stable_lamp_o,
  output logic zero_lamp_o,
  output logic standby_lamp_o,
  // display and level select
  output logic display_on_o,
  output logic signed [VAL_W-1:0] disp_value_o,
  output logic entry_o,
  output logic func_mode_o,
  output logic [DIG_W-1:0] digit_sel_o,
  output logic [LEVELS-1:0] level_select_o
);

  // ------------------------------
  // input synchronisers
  // ------------------------------
  logic [IN_W-1:0] meta_q;
  logic [IN_W-1:0] sync_q;
  logic ext_zero_d1_q;
  logic ext_hold_d1_q;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= {level_select_inputs_i, latch_i, comp_enable_i, ext_hold_i,
                 ext_zero_i, hold_key_i, down_key_i, up_key_i, zero_key_i,
                 function_key_i, cancel_key_i};
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ext_zero_d1_q <= 1'b0;
      ext_hold_d1_q <= 1'b0;
    end
    else
    begin
      ext_zero_d1_q <= sync_q[IN_EXT_ZERO];
      ext_hold_d1_q <= sync_q[IN_EXT_HOLD];
    end
  end

  logic ext_zero_rise;
  logic ext_hold_rise;
  logic latched;
  logic comp_on;
  assign ext_zero_rise = sync_q[IN_EXT_ZERO] && !ext_zero_d1_q;
  assign ext_hold_rise = sync_q[IN_EXT_HOLD] && !ext_hold_d1_q;
  assign latched = sync_q[IN_LATCH];
  assign comp_on = sync_q[IN_COMP_ON];

  // ------------------------------
  // key timers
  // ------------------------------
  logic cancel_short, cancel_long, func_short, func_long;
  logic zero_short, zero_long, up_short, down_short, hold_short;

  lcp_key_timer #(DEBOUNCE_CYCLES, LONG_CYCLES)
    u_cancel (.clock_i(clock_i), .rst_i(rst_i), .key_i(sync_q[IN_CANCEL]),
              .short_o(cancel_short), .long_o(cancel_long));
  lcp_key_timer #(DEBOUNCE_CYCLES, LONG_CYCLES)
    u_func (.clock_i(clock_i), .rst_i(rst_i), .key_i(sync_q[IN_FUNC]),
            .short_o(func_short), .long_o(func_long));
  lcp_key_timer #(DEBOUNCE_CYCLES, ZERO_CYCLES)
    u_zero (.clock_i(clock_i), .rst_i(rst_i), .key_i(sync_q[IN_ZERO]),
            .short_o(zero_short), .long_o(zero_long));
  lcp_key_timer #(DEBOUNCE_CYCLES, LONG_CYCLES)
    u_up (.clock_i(clock_i), .rst_i(rst_i), .key_i(sync_q[IN_UP]),
          .short_o(up_short), .long_o());
  lcp_key_timer #(DEBOUNCE_CYCLES, LONG_CYCLES)
    u_down (.clock_i(clock_i), .rst_i(rst_i), .key_i(sync_q[IN_DOWN]),
            .short_o(down_short), .long_o());
  lcp_key_timer #(DEBOUNCE_CYCLES, LONG_CYCLES)
    u_hold (.clock_i(clock_i), .rst_i(rst_i), .key_i(sync_q[IN_HOLD]),
            .short_o(hold_short), .long_o());

  // ------------------------------
  // control state and value entry
  // ------------------------------
  lcp_state_t state_q;
  logic signed [VAL_W-1:0] edit_q;
  logic [DIG_W-1:0] digit_q;
  logic signed [VAL_W-1:0] upper_q;
  logic signed [VAL_W-1:0] lower_q;
  logic entry;
  logic signed [VAL_W:0] step;
  logic signed [VAL_W:0] edit_up;
  logic signed [VAL_W:0] edit_dn;

  assign entry = (state_q == ST_EDIT_UPPER) || (state_q == ST_EDIT_LOWER);

  function automatic logic signed [VAL_W:0] pow10(input logic [DIG_W-1:0] d);
    logic signed [VAL_W:0] p;
    p = 25'sd1;
    for (int i = 0; i < DIGITS; i++)
    begin
      if (i < int'(d))
      begin
        p = 25'(p * 25'sd10);
      end
    end
    return p;
  endfunction

  assign step = pow10(digit_q);
  assign edit_up = 25'(edit_q) + step;
  assign edit_dn = 25'(edit_q) - step;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_MEASURE;
      edit_q <= '0;
      digit_q <= '0;
    end
    else if (cancel_short)
    begin
      // back one level; the entry buffer is simply dropped
      case (state_q) // see RULE_11
        ST_EDIT_UPPER: state_q <= ST_SHOW_UPPER;
        ST_EDIT_LOWER: state_q <= ST_SHOW_LOWER;
        default: state_q <= ST_MEASURE;
      endcase
    end
    else if (func_long && !entry)
    begin
      state_q <= ST_FUNC_SEL; // see RULE_12
    end
    else
    begin
      case (state_q)
        ST_MEASURE, ST_SHOW_UPPER, ST_SHOW_LOWER:
        begin
          if (up_short)
          begin
            state_q <= ST_SHOW_UPPER; // see RULE_15
          end
          else if (down_short)
          begin
            state_q <= ST_SHOW_LOWER; // see RULE_16
          end
          else if (func_short && !latched && state_q != ST_MEASURE)
          begin
            // short function press on a shown limit opens its entry
            state_q <= (state_q == ST_SHOW_UPPER) ? ST_EDIT_UPPER
                                                   : ST_EDIT_LOWER;
            edit_q <= (state_q == ST_SHOW_UPPER) ? upper_q : lower_q;
            digit_q <= '0;
          end
        end
        ST_EDIT_UPPER, ST_EDIT_LOWER:
        begin
          if (func_short)
          begin
            edit_q <= -edit_q; // see RULE_13
          end
          else if (zero_short)
          begin
            digit_q <= (digit_q == DIG_W'(DIGITS - 1)) ? '0
                                                       : digit_q + 3'h1; // see RULE_14
          end
          else if (up_short)
          begin
            edit_q <= (edit_up > 25'(VAL_MAX)) ? VAL_MAX
                                               : edit_up[VAL_W-1:0]; // see RULE_15
          end
          else if (down_short)
          begin
            edit_q <= (edit_dn < 25'(VAL_MIN)) ? VAL_MIN
                                               : edit_dn[VAL_W-1:0]; // see RULE_16
          end
          else if (hold_short)
          begin
            state_q <= (state_q == ST_EDIT_UPPER) ? ST_SHOW_UPPER
                                                   : ST_SHOW_LOWER; // see RULE_18
          end
        end
        default:
        begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // ------------------------------
  // limits and non-volatile copy
  // ------------------------------
  logic confirm;
  assign confirm = entry && hold_short && !cancel_short && !latched;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      upper_q <= UPPER_RST;
      lower_q <= LOWER_RST;
      nv_store_o <= 1'b0;
      nv_upper_o <= UPPER_RST;
      nv_lower_o <= LOWER_RST;
    end
    else
    begin
      nv_store_o <= confirm; // see RULE_19
      if (nv_load_i)
      begin
        upper_q <= nv_upper_i; // see RULE_19
        lower_q <= nv_lower_i;
      end
      else if (confirm && state_q == ST_EDIT_UPPER)
      begin
        upper_q <= edit_q; // see RULE_18
        nv_upper_o <= edit_q;
        nv_lower_o <= lower_q;
      end
      else if (confirm)
      begin
        lower_q <= edit_q; // see RULE_18
        nv_upper_o <= upper_q;
        nv_lower_o <= edit_q;
      end
    end
  end

  // ------------------------------
  // zero adjust and hold
  // ------------------------------
  logic signed [VAL_W-1:0] raw_q;
  logic signed [VAL_W-1:0] zero_off_q;
  logic hold_run_q;
  logic held_q;
  logic signed [VAL_W-1:0] held_val_q;
  logic signed [VAL_W-1:0] net_value;
  logic hold_toggle;

  assign net_value = VAL_W'(meas_value_i - zero_off_q);
  assign hold_toggle = (hold_short && !entry) || ext_hold_rise; // see RULE_22

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      raw_q <= '0;
      zero_off_q <= '0;
    end
    else
    begin
      if (meas_valid_i)
      begin
        raw_q <= meas_value_i;
      end
      if ((zero_long && !entry) || ext_zero_rise)
      begin
        zero_off_q <= raw_q; // see RULE_14 see RULE_22
      end
    end
  end

  // value is caught on the first fresh sample after hold starts
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hold_run_q <= 1'b0;
      held_q <= 1'b0;
      held_val_q <= '0;
    end
    else if (hold_toggle && hold_run_q)
    begin
      hold_run_q <= 1'b0; // see RULE_17
      held_q <= 1'b0;
    end
    else if (hold_toggle)
    begin
      hold_run_q <= 1'b1; // see RULE_17
    end
    else if (hold_run_q && !held_q && meas_valid_i)
    begin
      held_q <= 1'b1;
      held_val_q <= net_value;
    end
  end

  // ------------------------------
  // comparison and result contacts
  // ------------------------------
  logic signed [VAL_W-1:0] cmp_value;
  assign cmp_value = held_q ? held_val_q : net_value;

  // latch freezes contacts; disable drops them at once
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      upper_exceed_result_o <= 1'b0;
      in_range_result_o <= 1'b0;
      below_lower_result_o <= 1'b0;
      upper_exceed_lamp_o <= 1'b0;
      in_range_lamp_o <= 1'b0;
      below_lower_lamp_o <= 1'b0;
      level_reject_lamp_o <= 1'b0;
    end
    else if (!comp_on)
    begin
      upper_exceed_result_o <= 1'b0; // see RULE_20
      in_range_result_o <= 1'b0;
      below_lower_result_o <= 1'b0;
      upper_exceed_lamp_o <= 1'b0;
      in_range_lamp_o <= 1'b0;
      below_lower_lamp_o <= 1'b0;
      level_reject_lamp_o <= 1'b0;
    end
    else if (meas_valid_i && !latched)
    begin
      upper_exceed_result_o <= cmp_value > upper_q; // see RULE_01 see RULE_24
      upper_exceed_lamp_o <= cmp_value > upper_q;
      in_range_result_o <= (cmp_value >= lower_q)
                           && (cmp_value <= upper_q); // see RULE_02
      in_range_lamp_o <= (cmp_value >= lower_q) && (cmp_value <= upper_q);
      below_lower_result_o <= cmp_value < lower_q; // see RULE_03
      below_lower_lamp_o <= cmp_value < lower_q;
      level_reject_lamp_o <= level_mode_i && level_fail_i; // see RULE_04
    end
  end

  // ------------------------------
  // status lamps and display
  // ------------------------------
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stable_lamp_o <= 1'b0;
      zero_lamp_o <= 1'b0;
    end
    else if (meas_valid_i)
    begin
      stable_lamp_o <= meas_stable_i; // see RULE_08 see RULE_24
      zero_lamp_o <= cmp_value == '0; // see RULE_09
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      display_on_o <= 1'b1;
      standby_lamp_o <= 1'b0;
    end
    else if (cancel_long)
    begin
      display_on_o <= !display_on_o; // see RULE_10
      standby_lamp_o <= display_on_o;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      latch_lamp_o <= 1'b0;
      hold_active_lamp_o <= 1'b0;
      held_value_lamp_o <= 1'b0;
      level_select_o <= '0;
      disp_value_o <= '0;
      entry_o <= 1'b0;
      func_mode_o <= 1'b0;
      digit_sel_o <= '0;
    end
    else
    begin
      latch_lamp_o <= latched; // see RULE_05
      hold_active_lamp_o <= hold_run_q; // see RULE_06
      held_value_lamp_o <= held_q; // see RULE_07
      level_select_o <= sync_q[IN_LEVEL +: LEVELS]; // see RULE_21
      entry_o <= entry;
      func_mode_o <= state_q == ST_FUNC_SEL;
      digit_sel_o <= digit_q;
      case (state_q)
        ST_SHOW_UPPER: disp_value_o <= upper_q;
        ST_SHOW_LOWER: disp_value_o <= lower_q;
        ST_EDIT_UPPER, ST_EDIT_LOWER: disp_value_o <= edit_q;
        default: disp_value_o <= cmp_value;
      endcase
    end
  end

endmodule
`default_nettype wire
